// ### verilog/mcmr_consts.vh
`ifndef MCMR_CONSTS_VH
`define MCMR_CONSTS_VH

// transfer command byte layout
`define MCMR_CMD_DIR_BIT        7
`define MCMR_CMD_IDX_MSB        5
`define MCMR_CMD_IDX_LSB        0

// register indices
`define MCMR_OPCFG_INDEX        6'h09

// operating configuration field positions
`define MCMR_HPF_BYP_BIT        0
`define MCMR_LPF_BYP_BIT        1
`define MCMR_PULSE_OFF_BIT      2
`define MCMR_SAG_OFF_BIT        3
`define MCMR_SUSPEND_BIT        4
`define MCMR_TEMP_GO_BIT        5
`define MCMR_SOFT_RST_BIT       6
`define MCMR_CYCLE_ACC_BIT      7
`define MCMR_SHORT1_BIT         8
`define MCMR_SHORT2_BIT         9
`define MCMR_SWAP_BIT           10
`define MCMR_RATE_LSB           11
`define MCMR_RATE_MSB           12

// operating configuration reset value
`define MCMR_OPCFG_RESET        16'h000C

// soft reset quiet time
`define MCMR_CLK_PERIOD_NS      8
`define MCMR_SOFT_QUIET_NS      18000
`define MCMR_SOFT_QUIET_CYC     ((`MCMR_SOFT_QUIET_NS + `MCMR_CLK_PERIOD_NS - 1) / `MCMR_CLK_PERIOD_NS)

// waveform rate: master clock divided by base shifted by the select code
`define MCMR_RATE_BASE_DIV      128

`endif

// ### verilog/mcmr_wave_rate.v
`timescale 1ns/1ps
`include "mcmr_consts.vh"

module mcmr_wave_rate
#(
    parameter CNT_W = 10
)
(
    input  wire             clk,
    input  wire             reset_n,
    input  wire [1:0]       waveform_rate_select,
    output reg              wave_tick
);

    reg  [CNT_W-1:0] count_reg;
    wire [CNT_W-1:0] last_count;
    wire [CNT_W:0]   period_full;
    wire [31:0]      period_wide;

    // 128, 256, 512 or 1024 clocks per sample
    assign period_wide = `MCMR_RATE_BASE_DIV << waveform_rate_select;
    assign period_full = period_wide[CNT_W:0];
    assign last_count  = period_full[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= {CNT_W{1'b0}};
            wave_tick <= 1'b0;
        end
        else if (count_reg >= last_count)
        begin
            count_reg <= {CNT_W{1'b0}};
            wave_tick <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            wave_tick <= 1'b0;
        end
    end

endmodule

// ### verilog/mcmr_front_end.v
// Function
// - every transaction opens with one command byte
// - command byte is write-only, steers next phase
// - command bits 0-5 pick the register
// - bit 7 one: following data is write
// - bit 7 zero: following data is read
// - configuration register at 0x09, applied on write
// - bit 0 bypasses current high-pass, reset 0
// - bit 1 bypasses power low-pass, reset 0
// - bit 2 disables pulse output, reset 1
// - bit 3 disables sag detection, reset 1
// - bit 4 suspends both converters, reset 0
// - bit 5 starts temperature conversion, self-clears
// - soft reset, then 18 us without transfers
// - bit 7 selects line-cycle accumulation, reset 0
// - bit 10 swaps channel inputs between converters
// - bits 12:11 pick clock divide 128..1024
`timescale 1ns/1ps
`include "mcmr_consts.vh"

module mcmr_front_end
#(
    parameter QUIET_CYCLES = `MCMR_SOFT_QUIET_CYC
)
(
    input  wire             clk,
    input  wire             reset_n,
    input  wire             frame_active,
    input  wire             rx_valid,
    input  wire [7:0]       rx_byte,
    input  wire             tx_req,
    output reg              tx_valid,
    output reg  [7:0]       tx_byte,
    output reg  [5:0]       ext_index,
    output reg              ext_wr,
    output reg  [7:0]       ext_wdata,
    output reg              ext_rd,
    input  wire [7:0]       ext_rdata,
    input  wire             temp_done,
    output reg              temp_start,
    output reg              soft_reset_pulse,
    output reg              xfer_blocked,
    output reg              current_highpass_bypass,
    output reg              power_lowpass_bypass,
    output reg              pulse_output_off,
    output reg              sag_detect_off,
    output reg              converter_suspend,
    output reg              temperature_convert_go,
    output reg              line_cycle_accumulate,
    output reg              first_input_short,
    output reg              second_input_short,
    output reg              input_swap,
    output reg  [1:0]       waveform_rate_select,
    output reg              wave_tick
);

    localparam ST_CMD  = 2'b00;
    localparam ST_WR   = 2'b01;
    localparam ST_RD   = 2'b10;
    localparam ST_DONE = 2'b11;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [5:0]  target_register_index;
    reg         byte_sel_reg;
    reg  [7:0]  high_hold_reg;
    reg  [15:0] opcfg_reg;
    reg  [15:0] opcfg_next;
    reg  [11:0] quiet_reg;
    reg         cfg_write;
    reg         soft_hit;
    wire        quiet_busy;
    wire        rate_tick;
    wire        cmd_take;
    wire        wr_take;
    wire        rd_take;
    wire [15:0] written_word;

    assign quiet_busy   = (quiet_reg != 12'h000);
    assign written_word = {high_hold_reg, rx_byte};

    // bytes count only inside an open frame; commands wait out the quiet time
    assign cmd_take     = (state_reg == ST_CMD) && rx_valid && frame_active && !quiet_busy;
    assign wr_take      = (state_reg == ST_WR) && rx_valid && frame_active;
    assign rd_take      = (state_reg == ST_RD) && tx_req && frame_active;

    // transfer sequencer: command byte, then data bytes until frame ends; a config write ends after its second byte
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_CMD:
            begin
                if (rx_valid && !quiet_busy)
                begin
                    if (rx_byte[`MCMR_CMD_DIR_BIT])
                        state_next = ST_WR;
                    else
                        state_next = ST_RD;
                end
            end
            ST_WR:
            begin
                if (rx_valid && byte_sel_reg &&
                    target_register_index == `MCMR_OPCFG_INDEX)
                    state_next = ST_DONE;
            end
            ST_RD:
            begin
                state_next = ST_RD;
            end
            default:
            begin
                state_next = ST_DONE;
            end
        endcase
        if (!frame_active)
            state_next = ST_CMD;
    end

    always @*
    begin
        cfg_write = (state_reg == ST_WR) && rx_valid && byte_sel_reg &&
                    frame_active && (target_register_index == `MCMR_OPCFG_INDEX);
        soft_hit  = cfg_write && written_word[`MCMR_SOFT_RST_BIT];
    end

    // configuration register update
    always @*
    begin
        opcfg_next = opcfg_reg;
        if (temp_done)
            opcfg_next[`MCMR_TEMP_GO_BIT] = 1'b0;
        if (cfg_write)
        begin
            opcfg_next = written_word;
            opcfg_next[`MCMR_SOFT_RST_BIT] = 1'b0;
        end
        // a soft reset discards the rest of the written word
        if (soft_hit)
            opcfg_next = `MCMR_OPCFG_RESET;
    end

    // sequencer state and the configuration register
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_CMD;
            opcfg_reg <= `MCMR_OPCFG_RESET;
        end
        else
        begin
            state_reg <= state_next;
            opcfg_reg <= opcfg_next;
        end
    end

    // command capture and byte select; the select flips after each data byte
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            target_register_index <= 6'h00;
            byte_sel_reg          <= 1'b0;
            high_hold_reg         <= 8'h00;
        end
        else
        begin
            if (cmd_take)
            begin
                // command byte is consumed, never stored for readback
                target_register_index <= rx_byte[`MCMR_CMD_IDX_MSB:`MCMR_CMD_IDX_LSB];
                byte_sel_reg          <= 1'b0;
            end
            else if (wr_take)
            begin
                high_hold_reg <= rx_byte;
                byte_sel_reg  <= ~byte_sel_reg;
            end
            else if (rd_take)
            begin
                byte_sel_reg <= ~byte_sel_reg;
            end
            // a lone first byte is dropped when the frame closes
            if (!frame_active)
                byte_sel_reg <= 1'b0;
        end
    end

    // quiet time after a soft reset; commands are refused while it runs
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            quiet_reg <= 12'h000;
        end
        else if (soft_hit)
        begin
            quiet_reg <= QUIET_CYCLES[11:0];
        end
        else if (quiet_busy)
        begin
            quiet_reg <= quiet_reg - 12'h001;
        end
    end

    // byte paths toward other registers and back to the host
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_valid         <= 1'b0;
            tx_byte          <= 8'h00;
            ext_index        <= 6'h00;
            ext_wr           <= 1'b0;
            ext_wdata        <= 8'h00;
            ext_rd           <= 1'b0;
            temp_start       <= 1'b0;
            soft_reset_pulse <= 1'b0;
            xfer_blocked     <= 1'b0;
        end
        else
        begin
            tx_valid         <= 1'b0;
            ext_wr           <= 1'b0;
            ext_rd           <= 1'b0;
            temp_start       <= cfg_write && !soft_hit &&
                                written_word[`MCMR_TEMP_GO_BIT];
            soft_reset_pulse <= soft_hit;
            xfer_blocked     <= soft_hit || (quiet_reg > 12'h001);
            ext_index        <= target_register_index;
            // other registers pass through one byte per data phase
            if (state_reg == ST_WR && rx_valid && frame_active &&
                target_register_index != `MCMR_OPCFG_INDEX)
            begin
                ext_wr    <= 1'b1;
                ext_wdata <= rx_byte;
            end
            if (state_reg == ST_RD && tx_req && frame_active)
            begin
                tx_valid <= 1'b1;
                if (target_register_index == `MCMR_OPCFG_INDEX)
                begin
                    // high byte first, then low byte
                    if (byte_sel_reg)
                        tx_byte <= opcfg_reg[7:0];
                    else
                        tx_byte <= opcfg_reg[15:8];
                end
                else
                begin
                    ext_rd  <= 1'b1;
                    tx_byte <= ext_rdata;
                end
            end
        end
    end

    // configuration fields driven out as flops
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            current_highpass_bypass <= 1'b0;
            power_lowpass_bypass    <= 1'b0;
            pulse_output_off        <= 1'b1;
            sag_detect_off          <= 1'b1;
            converter_suspend       <= 1'b0;
            temperature_convert_go  <= 1'b0;
            line_cycle_accumulate   <= 1'b0;
            first_input_short       <= 1'b0;
            second_input_short      <= 1'b0;
            input_swap              <= 1'b0;
            waveform_rate_select    <= 2'b00;
            wave_tick               <= 1'b0;
        end
        else
        begin
            current_highpass_bypass <= opcfg_reg[`MCMR_HPF_BYP_BIT];
            power_lowpass_bypass    <= opcfg_reg[`MCMR_LPF_BYP_BIT];
            pulse_output_off        <= opcfg_reg[`MCMR_PULSE_OFF_BIT];
            sag_detect_off          <= opcfg_reg[`MCMR_SAG_OFF_BIT];
            converter_suspend       <= opcfg_reg[`MCMR_SUSPEND_BIT];
            temperature_convert_go  <= opcfg_reg[`MCMR_TEMP_GO_BIT];
            line_cycle_accumulate   <= opcfg_reg[`MCMR_CYCLE_ACC_BIT];
            first_input_short       <= opcfg_reg[`MCMR_SHORT1_BIT];
            second_input_short      <= opcfg_reg[`MCMR_SHORT2_BIT];
            input_swap              <= opcfg_reg[`MCMR_SWAP_BIT];
            waveform_rate_select    <= opcfg_reg[`MCMR_RATE_MSB:`MCMR_RATE_LSB];
            wave_tick               <= rate_tick;
        end
    end

    mcmr_wave_rate
    #(
        .CNT_W (10)
    )
    u_rate
    (
        .clk                  (clk),
        .reset_n              (reset_n),
        .waveform_rate_select (opcfg_reg[`MCMR_RATE_MSB:`MCMR_RATE_LSB]),
        .wave_tick            (rate_tick)
    );

endmodule

// ### sim/mcmr_assertions.sv
`timescale 1ns/1ps
module mcmr_checker (
    input wire       clk,
    input wire       reset_n,
    input wire       frame_active,
    input wire       rx_valid,
    input wire       tx_req,
    input wire       tx_valid,
    input wire [5:0] ext_index,
    input wire       ext_wr,
    input wire       temp_start,
    input wire       temperature_convert_go,
    input wire       soft_reset_pulse,
    input wire       xfer_blocked,
    input wire       pulse_output_off,
    input wire       sag_detect_off,
    input wire       wave_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_home; pulse_output_off && sag_detect_off; endsequence
    sequence s_gap; !wave_tick [*8]; endsequence
    property p_tx; tx_valid |-> $past(tx_req); endproperty
    a_tx: assert property (p_tx) else $error("tx without req");
    property p_wr; ext_wr |-> $past(rx_valid) && ext_index != 6'h09; endproperty
    a_wr: assert property (p_wr) else $error("bad ext write");
    property p_frm; (ext_wr || tx_valid) |-> $past(frame_active); endproperty
    a_frm: assert property (p_frm) else $error("access outside frame");
    property p_go; temp_start |-> ##[0:2] temperature_convert_go; endproperty
    a_go: assert property (p_go) else $error("temp bit not set");
    property p_blk; soft_reset_pulse |-> ##[0:1] xfer_blocked; endproperty
    a_blk: assert property (p_blk) else $error("no quiet time");
    property p_home; soft_reset_pulse |-> ##[0:2] s_home; endproperty
    a_home: assert property (p_home) else $error("config not reset");
    property p_quiet; xfer_blocked |-> !ext_wr && !temp_start; endproperty
    a_quiet: assert property (p_quiet) else $error("access in quiet time");
    property p_gap; wave_tick |=> s_gap; endproperty
    a_gap: assert property (p_gap) else $error("tick too soon");
endmodule
bind mcmr_front_end mcmr_checker u_chk (.clk(clk), .reset_n(reset_n),
    .frame_active(frame_active), .rx_valid(rx_valid), .tx_req(tx_req), .tx_valid(tx_valid),
    .ext_index(ext_index), .ext_wr(ext_wr), .temp_start(temp_start),
    .temperature_convert_go(temperature_convert_go), .soft_reset_pulse(soft_reset_pulse),
    .xfer_blocked(xfer_blocked), .pulse_output_off(pulse_output_off),
    .sag_detect_off(sag_detect_off), .wave_tick(wave_tick));

// ### sim/mcmr_host_model.sv
`timescale 1ns/1ps
module mcmr_host_model (
    input  wire       clk,
    input  wire       tx_valid,
    input  wire [7:0] tx_byte,
    output reg        frame_active = 1'b0,
    output reg        rx_valid = 1'b0,
    output reg  [7:0] rx_byte = 8'h00,
    output reg        tx_req = 1'b0
);
    // command byte, then nb data bytes msb first; released data line shows inverse
    task xfer(input wr, input [5:0] idx, input [15:0] d, input integer nb,
              output [15:0] q);
        integer i;
    begin
        q = 16'h0000;
        @(negedge clk);
        frame_active = 1'b1;
        rx_valid = 1'b1;
        rx_byte = {wr, 1'b0, idx};
        for (i = 0; i < nb; i = i + 1)
        begin
            @(negedge clk);
            if (wr)
                rx_byte = d[15 - 8 * i -: 8];
            else
            begin
                rx_valid = 1'b0;
                rx_byte = ~rx_byte;
                tx_req = 1'b1;
                @(negedge clk);
                tx_req = 1'b0;
                q = {q[7:0], tx_valid ? tx_byte : 8'hXX};
            end
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
        frame_active = 1'b0;
    end
    endtask
endmodule

// ### sim/test_meter_command_and_mode_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks = num_checks + 1; if ((a) !== (e)) begin \
    err_count = err_count + 1; $display("BAD %s exp %h got %h", n, e, a); end end
module test_meter_command_and_mode_regs;
    reg         clk;
    reg         reset_n = 1'b0;
    reg  [7:0]  ext_rdata = 8'hA5;
    reg         temp_done = 1'b0;
    reg  [7:0]  last_wd = 8'h00;
    reg  [15:0] q;
    integer     err_count = 0, num_checks = 0, cycles = 0, n_wr = 0, n_soft = 0, k, b;
    integer     n_rd = 0, n_go = 0;
    wire        frame_active, rx_valid, tx_req, tx_valid, ext_wr, ext_rd, temp_start;
    wire        soft_reset_pulse, xfer_blocked, wave_tick, temperature_convert_go;
    wire        current_highpass_bypass, power_lowpass_bypass, pulse_output_off;
    wire        sag_detect_off, converter_suspend, line_cycle_accumulate;
    wire        first_input_short, second_input_short, input_swap;
    wire [7:0]  rx_byte, tx_byte, ext_wdata;
    wire [5:0]  ext_index;
    wire [1:0]  waveform_rate_select;
    wire [12:0] cfg = {waveform_rate_select, input_swap, second_input_short, first_input_short,
        line_cycle_accumulate, 1'b0, temperature_convert_go, converter_suspend,
        sag_detect_off, pulse_output_off, power_lowpass_bypass, current_highpass_bypass};
    mcmr_host_model u_host (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .frame_active(frame_active), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req));
    mcmr_front_end #(.QUIET_CYCLES(20)) u_dut (.clk(clk), .reset_n(reset_n),
        .frame_active(frame_active), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .ext_index(ext_index), .ext_wr(ext_wr),
        .ext_wdata(ext_wdata), .ext_rd(ext_rd), .ext_rdata(ext_rdata), .temp_done(temp_done),
        .temp_start(temp_start), .soft_reset_pulse(soft_reset_pulse),
        .xfer_blocked(xfer_blocked), .current_highpass_bypass(current_highpass_bypass),
        .power_lowpass_bypass(power_lowpass_bypass), .pulse_output_off(pulse_output_off),
        .sag_detect_off(sag_detect_off), .converter_suspend(converter_suspend),
        .temperature_convert_go(temperature_convert_go),
        .line_cycle_accumulate(line_cycle_accumulate), .first_input_short(first_input_short),
        .second_input_short(second_input_short), .input_swap(input_swap),
        .waveform_rate_select(waveform_rate_select), .wave_tick(wave_tick));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        n_soft = n_soft + soft_reset_pulse;
        n_rd = n_rd + ext_rd;
        n_go = n_go + temp_start;
        if (ext_wr)
        begin
            n_wr = n_wr + 1;
            last_wd = ext_wdata;
        end
        if (cycles == 30000)
        begin
            err_count = err_count + 1;
            report_and_stop;
        end
    end
    task wcfg(input [15:0] d);
    begin
        u_host.xfer(1'b1, 6'h09, d, 2, q);
        repeat (2) @(negedge clk);
    end
    endtask
    task t_reset;
    begin
        `CHK("cfg", 13'h000C, cfg)
        u_host.xfer(1'b0, 6'h09, 16'h0000, 2, q);
        `CHK("rd", 16'h000C, q)
        u_host.xfer(1'b1, 6'h1F, 16'h3C00, 1, q);
        @(negedge clk);
        `CHK("wd", 8'h3C, last_wd)
        u_host.xfer(1'b0, 6'h26, 16'h0000, 1, q);
        `CHK("rx", 8'hA5, q[7:0])
        `CHK("ird", 1, n_rd)
        `CHK("idx", 6'h26, ext_index)
        wcfg(16'h0000);
        u_host.xfer(1'b1, 6'h09, 16'hFFFF, 1, q);
        repeat (2) @(negedge clk);
        `CHK("lone", 13'h0000, cfg)
        `CHK("nwr", 1, n_wr)
        $display("t_reset done");
    end
    endtask
    task t_fields;
    begin
        for (b = 0; b < 16; b = b + 1)
            if (b != 6)
            begin
                wcfg(16'h0001 << b);
                `CHK("out", 13'h0001 << b, (b < 13) ? cfg : 13'h0000)
                u_host.xfer(1'b0, 6'h09, 16'h0000, 2, q);
                `CHK("rd", 16'h0001 << b, q)
            end
        wcfg(16'h0020);
        `CHK("go", 1'b1, temperature_convert_go)
        `CHK("tstart", 2, n_go)
        temp_done = 1'b1;
        @(negedge clk);
        temp_done = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("temp", 1'b0, temperature_convert_go)
        $display("t_fields done");
    end
    endtask
    task t_soft;
    begin
        wcfg(16'h1F43);
        `CHK("soft", 14'h300C, {n_soft[0], xfer_blocked, cfg[11:0]})
        u_host.xfer(1'b1, 6'h09, 16'h0003, 2, q);
        for (k = 0; k < 100 && xfer_blocked; k = k + 1)
            @(negedge clk);
        `CHK("blk", 13'h000C, cfg)
        wcfg(16'h0003);
        `CHK("after", 13'h0003, cfg)
        $display("t_soft done");
    end
    endtask
    task t_rate;
    begin
        for (b = 0; b < 4; b = b + 1)
        begin
            wcfg(b << 11);
            for (k = 0; k < 2100 && !wave_tick; k = k + 1)
                @(negedge clk);
            @(negedge clk);
            for (k = 1; k < 2100 && !wave_tick; k = k + 1)
                @(negedge clk);
            `CHK("period", 128 << b, k)
        end
        $display("t_rate done");
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        t_reset;
        t_fields;
        t_soft;
        t_rate;
        report_and_stop;
    end
endmodule
